/* File: core/level_control_timing_gate.sv */
// Level control loop: timing register, noise gate and input gain steering
`timescale 1ns/10ps
`default_nettype none
module level_control_timing_gate #(
    parameter int unsigned DECAY_BASE_CYC = level_pkg::DECAY_N_BASE_CYC,
    parameter int unsigned ATK_N8_CYC     = level_pkg::ATK_N8_CYC,
    // Code nine doubles code eight, so it follows a shortened code eight
    parameter int unsigned ATK_N9_CYC     = 2 * ATK_N8_CYC,
    parameter int unsigned ATK_NMAX_CYC   = level_pkg::ATK_NMAX_CYC,
    parameter int unsigned ATK_L8_CYC     = level_pkg::ATK_L8_CYC,
    parameter int unsigned ATK_L9_CYC     = level_pkg::ATK_L9_CYC,
    parameter int unsigned ATK_LMAX_CYC   = level_pkg::ATK_LMAX_CYC
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire level_pkg::reg_req_t reg_req,
    input  wire logic signed [7:0]   level_meas,
    output logic [8:0]               reg_rdata,
    output logic [5:0]               pga_gain
);
    import level_pkg::*;

    logic [8:0]   loop_ctrl;
    logic [8:0]   loop_target;
    loop_timing_t level_loop_timing;
    gate_ctrl_t   noise_gate_control;
    logic [8:0]   manual_word;
    logic [5:0]   loop_gain;
    loop_state_t  state;
    loop_state_t  next_state;

    // Register writes; gate upper bits are never stored so they always read zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            loop_ctrl          <= LOOP_CTRL_RST;
            loop_target        <= LOOP_TARGET_RST;
            level_loop_timing  <= loop_timing_t'(LOOP_TIMING_RST);
            noise_gate_control <= gate_ctrl_t'(NOISE_GATE_RST);
            manual_word        <= MANUAL_GAIN_RST;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ADDR_LOOP_CTRL) begin
                loop_ctrl <= reg_req.wdata;
            end else if (reg_req.addr == ADDR_LOOP_TARGET) begin
                loop_target <= reg_req.wdata;
            end else if (reg_req.addr == ADDR_LOOP_TIMING) begin
                level_loop_timing <= loop_timing_t'(reg_req.wdata);
            end else if (reg_req.addr == ADDR_NOISE_GATE) begin
                noise_gate_control <= gate_ctrl_t'({5'h00, reg_req.wdata[3:0]});
            end else if (reg_req.addr == ADDR_MANUAL_GAIN) begin
                manual_word <= {1'b0, reg_req.wdata[7:0]};
            end
        end
    end

    wire        level_loop_on     = loop_ctrl[LOOP_ON_BIT];
    wire  [3:0] level_target_code = loop_target[TARGET_LSB +: 4];
    wire  [5:0] manual_input_gain = manual_word[MANUAL_GAIN_LSB +: 6];
    wire        limiter_select    = level_loop_timing.limiter_select;
    wire  [3:0] gain_release_rate = level_loop_timing.gain_release_rate;
    wire  [3:0] gain_attack_rate  = level_loop_timing.gain_attack_rate;
    wire        noise_gate_on     = noise_gate_control.noise_gate_on;
    wire  [2:0] noise_gate_level  = noise_gate_control.noise_gate_level;

    // Readback mux; unmapped addresses read zero
    wire  [8:0] next_rdata =
        (reg_req.addr == ADDR_LOOP_CTRL)   ? loop_ctrl :
        (reg_req.addr == ADDR_LOOP_TARGET) ? loop_target :
        (reg_req.addr == ADDR_LOOP_TIMING) ? 9'(level_loop_timing) :
        (reg_req.addr == ADDR_NOISE_GATE)  ? 9'(noise_gate_control) :
        (reg_req.addr == ADDR_MANUAL_GAIN) ? manual_word : 9'h000;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 9'h000;
        end else if (reg_req.rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Step periods; limiter is the normal decay shifted down by two
    wire  [3:0] release_eff = (gain_release_rate >= RATE_CODE_SAT) ? RATE_CODE_SAT
                                                                   : gain_release_rate;
    wire period_t decay_norm = period_t'(DECAY_BASE_CYC) << release_eff;
    wire period_t decay_lim  = decay_norm >> 2;
    wire period_t atk_norm_dbl = period_t'(ATK_N_BASE_CYC) << gain_attack_rate[2:0];
    wire period_t atk_lim_dbl  = period_t'(ATK_L_BASE_CYC) << gain_attack_rate[2:0];
    // The long attack codes do not follow the doubling series, so they are listed
    wire period_t atk_norm =
        (gain_attack_rate >= RATE_CODE_SAT) ? period_t'(ATK_NMAX_CYC) :
        (gain_attack_rate == RATE_CODE_9)   ? period_t'(ATK_N9_CYC) :
        (gain_attack_rate == RATE_CODE_8)   ? period_t'(ATK_N8_CYC) : atk_norm_dbl;
    wire period_t atk_lim =
        (gain_attack_rate >= RATE_CODE_SAT) ? period_t'(ATK_LMAX_CYC) :
        (gain_attack_rate == RATE_CODE_9)   ? period_t'(ATK_L9_CYC) :
        (gain_attack_rate == RATE_CODE_8)   ? period_t'(ATK_L8_CYC) : atk_lim_dbl;
    wire period_t decay_period  = limiter_select ? decay_lim : decay_norm;
    wire period_t attack_period = limiter_select ? atk_lim : atk_norm;

    // Level comparisons in 0.75 dB units
    wire logic signed [7:0] target_level =
        TARGET_BASE + $signed({3'b000, level_target_code, 1'b0});
    wire logic signed [7:0] gate_level =
        GATE_BASE - $signed({2'b00, noise_gate_level, 3'b000});
    wire too_loud   = level_meas > target_level;
    wire too_quiet  = level_meas < target_level;
    wire gate_shut  = noise_gate_on && (level_meas < gate_level);

    always_comb begin
        next_state = LOOP_HOLD;
        case (1'b1)
            !level_loop_on:          next_state = LOOP_HOLD;
            too_loud:                next_state = LOOP_ATTACK;
            too_quiet && !gate_shut: next_state = LOOP_DECAY;
            default:                 next_state = LOOP_HOLD;
        endcase
    end

    logic attack_tick;
    logic decay_tick;

    step_timer #(.W(24)) attack_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (state == LOOP_ATTACK && next_state == LOOP_ATTACK),
        .period (attack_period),
        .tick   (attack_tick)
    );

    step_timer #(.W(24)) decay_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (state == LOOP_DECAY && next_state == LOOP_DECAY),
        .period (decay_period),
        .tick   (decay_tick)
    );

    // While the loop is off its gain follows the manual value, so enabling it starts smoothly
    wire  [5:0] next_loop_gain =
        !level_loop_on ? manual_input_gain :
        (attack_tick && state == LOOP_ATTACK && loop_gain != GAIN_MIN) ? loop_gain - 6'h01 :
        (decay_tick && state == LOOP_DECAY && !gate_shut && loop_gain != GAIN_MAX)
            ? loop_gain + 6'h01 : loop_gain;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state     <= LOOP_HOLD;
            loop_gain <= MANUAL_GAIN_RST[5:0];
            pga_gain  <= MANUAL_GAIN_RST[5:0];
        end else begin
            state     <= next_state;
            loop_gain <= next_loop_gain;
            pga_gain  <= level_loop_on ? next_loop_gain : manual_input_gain;
        end
    end

    timing_reset_a: assert property (@(posedge clk)
        $past(!resetn) |-> 9'(level_loop_timing) == LOOP_TIMING_RST)
        else $error("timing word not at reset value");
    mode_select_a: assert property (@(posedge clk) disable iff (!resetn)
        limiter_select |-> (decay_period == decay_lim && attack_period == atk_lim
                            && attack_period < atk_norm && decay_period < decay_norm))
        else $error("limiter mode not using faster limiter timings");
    decay_base_a: assert property (@(posedge clk) disable iff (!resetn)
        gain_release_rate == 4'h8 |-> decay_norm == period_t'(DECAY_BASE_CYC) * 256)
        else $error("normal decay period wrong");
    decay_quarter_a: assert property (@(posedge clk) disable iff (!resetn)
        decay_lim * 4 == decay_norm)
        else $error("limiter decay not a quarter of normal");
    decay_sat_a: assert property (@(posedge clk) disable iff (!resetn)
        gain_release_rate >= RATE_CODE_SAT |-> decay_norm == period_t'(DECAY_BASE_CYC) * 1024)
        else $error("decay saturation wrong");
    attack_base_a: assert property (@(posedge clk) disable iff (!resetn)
        gain_attack_rate == 4'h0 |-> atk_norm == period_t'(ATK_N_BASE_CYC)
                                  && atk_lim == period_t'(ATK_L_BASE_CYC))
        else $error("attack base period wrong");
    attack_eight_a: assert property (@(posedge clk) disable iff (!resetn)
        gain_attack_rate == RATE_CODE_8 |-> atk_lim == period_t'(ATK_L8_CYC))
        else $error("attack code eight period wrong");
    attack_sat_a: assert property (@(posedge clk) disable iff (!resetn)
        gain_attack_rate == 4'hf |-> atk_norm == period_t'(ATK_NMAX_CYC))
        else $error("attack saturation wrong");
    gate_read_a: assert property (@(posedge clk) disable iff (!resetn)
        reg_req.rd && reg_req.addr == ADDR_NOISE_GATE |=> reg_rdata[8:4] == 5'h00)
        else $error("gate register upper bits not zero");
    manual_gain_a: assert property (@(posedge clk) disable iff (!resetn)
        !level_loop_on ##1 !level_loop_on |-> pga_gain == $past(manual_input_gain))
        else $error("manual gain not applied while loop off");
    gate_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        level_loop_on && gate_shut && !too_loud ##1 level_loop_on
            |-> loop_gain <= $past(loop_gain))
        else $error("gain raised while noise gate shut");
    attack_step_a: assert property (@(posedge clk) disable iff (!resetn)
        level_loop_on && attack_tick && state == LOOP_ATTACK && loop_gain != GAIN_MIN
            ##1 level_loop_on |-> loop_gain == $past(loop_gain) - 6'h01)
        else $error("attack step did not lower gain");
endmodule : level_control_timing_gate
`default_nettype wire

/* File: core/level_pkg.sv */
// Shared constants and types for the level control timing and noise gate block
package level_pkg;
    localparam int CLK_PERIOD_NS = 100;

    // Register addresses on the 7-bit serial control port
    localparam logic [6:0] ADDR_LOOP_CTRL   = 7'h20;
    localparam logic [6:0] ADDR_LOOP_TARGET = 7'h21;
    localparam logic [6:0] ADDR_LOOP_TIMING = 7'h22;
    localparam logic [6:0] ADDR_NOISE_GATE  = 7'h23;
    localparam logic [6:0] ADDR_MANUAL_GAIN = 7'h2d;

    // Reset values
    localparam logic [8:0] LOOP_CTRL_RST   = 9'h038;
    localparam logic [8:0] LOOP_TARGET_RST = 9'h00b;
    localparam logic [8:0] LOOP_TIMING_RST = 9'h032;
    localparam logic [8:0] NOISE_GATE_RST  = 9'h000;
    localparam logic [8:0] MANUAL_GAIN_RST = 9'h010;

    // Field positions in words that are not carried as structs
    localparam int LOOP_ON_BIT    = 8;
    localparam int TARGET_LSB     = 0;
    localparam int MANUAL_GAIN_LSB = 0;

    // Step times as printed, in microseconds
    localparam int DECAY_N_BASE_US = 500;
    localparam int DECAY_L_BASE_US = 125;
    localparam int ATK_N_BASE_US   = 125;
    localparam int ATK_L_BASE_US   = 31;
    localparam int ATK_N8_US       = 26500;
    localparam int ATK_N9_US       = 53000;
    localparam int ATK_NMAX_US     = 128000;
    localparam int ATK_L8_US       = 7900;
    localparam int ATK_L9_US       = 15870;
    localparam int ATK_LMAX_US     = 31700;

    // Same times as clock counts
    localparam int DECAY_N_BASE_CYC = DECAY_N_BASE_US * 1000 / CLK_PERIOD_NS;
    localparam int DECAY_L_BASE_CYC = DECAY_L_BASE_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_N_BASE_CYC   = ATK_N_BASE_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_L_BASE_CYC   = ATK_L_BASE_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_N8_CYC       = ATK_N8_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_N9_CYC       = ATK_N9_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_NMAX_CYC     = ATK_NMAX_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_L8_CYC       = ATK_L8_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_L9_CYC       = ATK_L9_US * 1000 / CLK_PERIOD_NS;
    localparam int ATK_LMAX_CYC     = ATK_LMAX_US * 1000 / CLK_PERIOD_NS;

    // Rate codes where the doubling series stops
    localparam logic [3:0] RATE_CODE_8   = 4'h8;
    localparam logic [3:0] RATE_CODE_9   = 4'h9;
    localparam logic [3:0] RATE_CODE_SAT = 4'ha;

    // Levels in 0.75 dB units: target -28.5 dB + 1.5 dB/code, gate -39 dB - 6 dB/code
    localparam logic signed [7:0] TARGET_BASE = -8'sd38;
    localparam logic signed [7:0] GATE_BASE   = -8'sd52;
    localparam logic [5:0] GAIN_MAX = 6'h3f;
    localparam logic [5:0] GAIN_MIN = 6'h00;

    typedef logic [23:0] period_t;

    typedef struct packed {
        logic       limiter_select;
        logic [3:0] gain_release_rate;
        logic [3:0] gain_attack_rate;
    } loop_timing_t;

    typedef struct packed {
        logic [4:0] unused_zero;
        logic       noise_gate_on;
        logic [2:0] noise_gate_level;
    } gate_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [8:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        LOOP_HOLD   = 2'b00,
        LOOP_ATTACK = 2'b01,
        LOOP_DECAY  = 2'b10
    } loop_state_t;
endpackage : level_pkg

/* File: core/step_timer.sv */
// Step period timer, cleared while run is low, that pulses once per elapsed period
`timescale 1ns/10ps
`default_nettype none
module step_timer #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         run,
    input  wire logic [W-1:0] period,
    output logic              tick
);
    logic [W-1:0] count;
    wire          last = (count >= period - W'(1));

    always_ff @(posedge clk) begin
        if (!resetn || !run) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= last ? '0 : count + W'(1);
            tick  <= last;
        end
    end
endmodule : step_timer
`default_nettype wire

/* File: verif/tb_level_control_timing_gate.sv */
// Self-checking testbench for the level control timing and noise gate block
`timescale 1ns/10ps
`default_nettype none
module tb_level_control_timing_gate;
    import level_pkg::*;
    logic              clk;
    logic              resetn;
    reg_req_t          reg_req;
    logic signed [7:0] level_meas;
    logic [8:0]        reg_rdata;
    logic [5:0]        pga_gain;
    int                fail_count;
    int                checks;

    // Shortened step counts keep the saturated codes within a short run;
    // normal code nine doubles code eight, limiter code nine is not exercised
    level_control_timing_gate #(
        .DECAY_BASE_CYC(8), .ATK_N8_CYC(40), .ATK_NMAX_CYC(160),
        .ATK_L8_CYC(12), .ATK_LMAX_CYC(48)
    ) u_dut (
        .clk(clk), .resetn(resetn), .reg_req(reg_req), .level_meas(level_meas),
        .reg_rdata(reg_rdata), .pga_gain(pga_gain)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req.wr = 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [6:0] a, input logic [8:0] exp);
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 9'h000};
        @(negedge clk);
        reg_req.rd = 1'b0;
        chk(reg_rdata, exp, "read data");
    endtask : reg_check

    task automatic test_reset();
        chk(pga_gain, 6'h10, "gain after reset");
        reg_check(ADDR_LOOP_CTRL, LOOP_CTRL_RST);
        reg_check(ADDR_LOOP_TARGET, LOOP_TARGET_RST);
        reg_check(ADDR_LOOP_TIMING, 9'h032);
        reg_check(ADDR_NOISE_GATE, 9'h000);
        reg_check(ADDR_MANUAL_GAIN, MANUAL_GAIN_RST);
        reg_check(7'h24, 9'h000);
        $display("test reset values done");
    endtask : test_reset

    task automatic test_regs();
        reg_write(ADDR_LOOP_TIMING, 9'h1ff);
        reg_check(ADDR_LOOP_TIMING, 9'h1ff);
        reg_write(ADDR_LOOP_TIMING, 9'h0a5);
        reg_check(ADDR_LOOP_TIMING, 9'h0a5);
        reg_write(ADDR_NOISE_GATE, 9'h1ff);
        reg_check(ADDR_NOISE_GATE, 9'h00f);
        reg_write(ADDR_NOISE_GATE, 9'h1f2);
        reg_check(ADDR_NOISE_GATE, 9'h002);
        // Unmapped write must not alias onto the loop timing register
        reg_write(7'h24, 9'h1ff);
        reg_check(7'h24, 9'h000);
        reg_check(ADDR_LOOP_TIMING, 9'h0a5);
        $display("test register access done");
    endtask : test_regs

    task automatic test_manual();
        level_meas = 8'sd0;
        reg_write(ADDR_MANUAL_GAIN, 9'h025);
        repeat (2) @(negedge clk);
        chk(pga_gain, 6'h25, "manual gain");
        reg_write(ADDR_MANUAL_GAIN, 9'h03f);
        repeat (50) @(negedge clk);
        chk(pga_gain, 6'h3f, "manual gain held with loop off");
        $display("test manual gain done");
    endtask : test_manual

    task automatic wait_step(input int lim, output int n);
        logic [5:0] prev;
        prev = pga_gain;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pga_gain === prev && n < lim);
    endtask : wait_step

    // Measures the spacing of two gain steps in one direction
    task automatic step_period(input logic lim, input logic up, input logic [3:0] code,
                               input int exp_cyc);
        logic [5:0] g0;
        int         n;
        reg_write(ADDR_LOOP_CTRL, LOOP_CTRL_RST);
        reg_write(ADDR_MANUAL_GAIN, 9'h020);
        reg_write(ADDR_LOOP_TIMING, {lim, up ? code : 4'h0, up ? 4'h0 : code});
        level_meas = up ? -8'sd30 : 8'sd0;
        reg_write(ADDR_LOOP_CTRL, LOOP_CTRL_RST | 9'h100);
        // The first step also carries the entry latency, so it is skipped
        wait_step(2 * exp_cyc + 50, n);
        g0 = pga_gain;
        wait_step(2 * exp_cyc + 50, n);
        chk(n, exp_cyc, "cycles per gain step");
        chk(pga_gain, up ? g0 + 6'h01 : g0 - 6'h01, "single step size");
        $display("test step period mode %0d up %0d code %0d done", lim, up, code);
    endtask : step_period

    // dir: 0 hold, 1 rising, 2 falling, judged after a fixed settling span
    task automatic loop_dir(input logic [8:0] gate, input logic [3:0] target,
                            input logic signed [7:0] lvl, input logic [1:0] dir);
        logic [1:0] got;
        reg_write(ADDR_LOOP_CTRL, LOOP_CTRL_RST);
        reg_write(ADDR_MANUAL_GAIN, 9'h020);
        reg_write(ADDR_LOOP_TIMING, 9'h008);
        reg_write(ADDR_NOISE_GATE, gate);
        reg_write(ADDR_LOOP_TARGET, {5'h00, target});
        level_meas = lvl;
        reg_write(ADDR_LOOP_CTRL, LOOP_CTRL_RST | 9'h100);
        repeat (100) @(negedge clk);
        got = (pga_gain > 6'h20) ? 2'd1 : (pga_gain < 6'h20) ? 2'd2 : 2'd0;
        chk(got, dir, "loop direction");
        $display("test loop direction gate %0h target %0d level %0d done", gate, target, lvl);
    endtask : loop_dir

    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #(100000 * 100);
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        fail_count = 0;
        checks = 0;
        resetn = 1'b0;
        reg_req = '0;
        level_meas = 8'sd0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        test_reset();
        test_regs();
        test_manual();
        step_period(1'b0, 1'b0, 4'h0, ATK_N_BASE_CYC);
        step_period(1'b0, 1'b0, 4'h1, 2 * ATK_N_BASE_CYC);
        step_period(1'b0, 1'b0, 4'h8, 40);
        step_period(1'b0, 1'b0, 4'h9, 80);
        step_period(1'b0, 1'b0, 4'ha, 160);
        step_period(1'b0, 1'b0, 4'hf, 160);
        step_period(1'b1, 1'b0, 4'h0, ATK_L_BASE_CYC);
        step_period(1'b1, 1'b0, 4'h8, 12);
        step_period(1'b1, 1'b0, 4'ha, 48);
        step_period(1'b1, 1'b0, 4'hf, 48);
        step_period(1'b0, 1'b1, 4'h0, 8);
        step_period(1'b0, 1'b1, 4'h1, 16);
        step_period(1'b0, 1'b1, 4'h8, 8 << 8);
        step_period(1'b0, 1'b1, 4'ha, 8 << 10);
        step_period(1'b0, 1'b1, 4'hf, 8 << 10);
        step_period(1'b1, 1'b1, 4'h0, 2);
        step_period(1'b1, 1'b1, 4'h8, 2 << 8);
        step_period(1'b1, 1'b1, 4'hf, 2 << 10);
        loop_dir(9'h000, 4'hb, -8'sd120, 2'd1);
        loop_dir(9'h009, 4'hb, -8'sd61, 2'd0);
        loop_dir(9'h009, 4'hb, -8'sd59, 2'd1);
        loop_dir(9'h00f, 4'hb, -8'sd109, 2'd0);
        loop_dir(9'h00f, 4'hb, -8'sd107, 2'd1);
        loop_dir(9'h000, 4'hf, -8'sd9, 2'd1);
        loop_dir(9'h000, 4'hf, -8'sd7, 2'd2);
        loop_dir(9'h000, 4'h0, -8'sd37, 2'd2);
        loop_dir(9'h000, 4'h0, -8'sd39, 2'd1);
        stop_test();
    end
endmodule : tb_level_control_timing_gate
`default_nettype wire
